// ---- rcc_top.sv ----
// correlator configuration registers with APB slave and derived receive controls
`timescale 1ns/1ps
`default_nettype none
module rcc_top #(
    parameter int SLEEP_IDLE_CYC = rcc_pkg::SLEEP_IDLE_CYC,
    parameter int EXIT_SHORT_CYC = rcc_pkg::EXIT_SHORT_CYC,
    parameter int EXIT_LONG_CYC  = rcc_pkg::EXIT_LONG_CYC
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        corr_pulse,
    input  wire logic        rx_on,
    output logic             agc_link,
    output logic             summation_en,
    output logic      [7:0]  vref_offset_mv,
    output logic      [7:0]  squelch_step_mv,
    output logic      [5:0]  start_detect_cnt,
    output logic             coll_eq_slicer,
    output logic      [6:0]  coll_level_pct,
    output logic             fast_slicer,
    output logic             phase_corr_skip,
    output logic      [4:0]  ref_tc_tenths,
    output logic      [6:0]  end_level_pct,
    output logic             end_detect_en,
    output logic             stream_424k,
    output logic             corr_sleep
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0]              cfg_one_q;
    logic [7:0]              cfg_two_q;
    logic [1:0]              mode_q;
    logic [rcc_pkg::CNT_W-1:0] cnt_q;
    logic [rcc_pkg::CNT_W-1:0] cnt_d;
    rcc_pkg::rcc_slp_t       slp_q;
    rcc_pkg::rcc_slp_t       slp_d;
    logic                    rx_on_q;

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire logic access   = psel & penable;
    wire logic hit_one  = paddr == rcc_pkg::ADDR_CFG_ONE;
    wire logic hit_two  = paddr == rcc_pkg::ADDR_CFG_TWO;
    wire logic hit_stat = paddr == rcc_pkg::ADDR_STATUS;
    wire logic hit_mode = paddr == rcc_pkg::ADDR_MODE;
    wire logic mapped   = hit_one | hit_two | hit_stat | hit_mode;
    wire logic wr_one   = access & pwrite & hit_one;
    wire logic wr_two   = access & pwrite & hit_two;
    wire logic wr_mode  = access & pwrite & hit_mode;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    wire logic is_bpsk = mode_q == rcc_pkg::STD_BPSK;
    wire logic is_106a = mode_q == rcc_pkg::STD_A106;
    wire logic b6      = cfg_one_q[rcc_pkg::B_COLL_PH];
    wire logic b2      = cfg_one_q[rcc_pkg::B_SLICER_TC];
    wire logic b1      = cfg_one_q[rcc_pkg::B_COLL_MSB];
    wire logic b0      = cfg_one_q[rcc_pkg::B_COLL_LSB];
    wire logic long_st = cfg_one_q[rcc_pkg::B_START_LEN];
    wire logic sq_hi   = cfg_one_q[rcc_pkg::B_SQUELCH];
    wire logic [1:0] coll_sel = {b1, b0};
    wire logic [6:0] coll_pct =
        (coll_sel == 2'h0) ? rcc_pkg::COLL_PCT0 :
        (coll_sel == 2'h1) ? rcc_pkg::COLL_PCT1 :
        (coll_sel == 2'h2) ? rcc_pkg::COLL_PCT2 : rcc_pkg::COLL_PCT3;
    wire logic [5:0] start_cnt = long_st ?
        (is_106a ? rcc_pkg::START_106_LONG : rcc_pkg::START_HI_LONG) :
        (is_106a ? rcc_pkg::START_106_SHORT : rcc_pkg::START_HI_SHORT);
    wire logic [rcc_pkg::CNT_W-1:0] exit_cyc = (mode_q == rcc_pkg::STD_SLOW) ?
        rcc_pkg::CNT_W'(EXIT_LONG_CYC) : rcc_pkg::CNT_W'(EXIT_SHORT_CYC);
    wire logic [rcc_pkg::CNT_W-1:0] idle_cyc = rcc_pkg::CNT_W'(SLEEP_IDLE_CYC);
    wire logic rx_on_rise = rx_on & ~rx_on_q;
    wire logic [31:0] rd_mux =
        hit_one  ? {24'h00_0000, cfg_one_q} :
        hit_two  ? {24'h00_0000, cfg_two_q & rcc_pkg::CFG_TWO_MASK} :
        hit_stat ? {30'h0000_0000, slp_q} :
        hit_mode ? {30'h0000_0000, mode_q} : 32'h0000_0000;

    // ------------------------------------------------------------
    // sleep state machine
    // ------------------------------------------------------------
    // counts idle cycles while awake, wake time while waking
    always_comb
    begin
        slp_d = slp_q;
        cnt_d = cnt_q + 1'b1;
        unique case (slp_q)
            rcc_pkg::SLP_AWAKE:
            begin
                if (corr_pulse)
                    cnt_d = '0;
                else if (cnt_q >= idle_cyc - 1'b1)
                begin
                    slp_d = rcc_pkg::SLP_ASLEEP;
                    cnt_d = '0;
                end
            end
            rcc_pkg::SLP_ASLEEP:
            begin
                cnt_d = '0;
                if (cfg_two_q[rcc_pkg::B_SLEEP_EXIT])
                begin
                    if (rx_on_rise)
                        slp_d = rcc_pkg::SLP_AWAKE;
                end
                else
                    slp_d = rcc_pkg::SLP_WAKING;
            end
            rcc_pkg::SLP_WAKING:
            begin
                if (cnt_q >= exit_cyc - 1'b1)
                begin
                    slp_d = rcc_pkg::SLP_AWAKE;
                    cnt_d = '0;
                end
            end
            default:
            begin
                slp_d = rcc_pkg::SLP_AWAKE;
                cnt_d = '0;
            end
        endcase
    end

    // sleep state and counter
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            slp_q   <= rcc_pkg::SLP_AWAKE;
            cnt_q   <= '0;
            rx_on_q <= 1'b0;
        end
        else
        begin
            slp_q   <= slp_d;
            cnt_q   <= cnt_d;
            rx_on_q <= rx_on;
        end
    end

    // ------------------------------------------------------------
    // registers and apb answer
    // ------------------------------------------------------------
    // software writes, zero wait state read data
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cfg_one_q <= rcc_pkg::RST_CFG_ONE;
            cfg_two_q <= rcc_pkg::RST_CFG_TWO;
            mode_q    <= rcc_pkg::RST_MODE;
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
        end
        else
        begin
            if (wr_one)
                cfg_one_q <= pwdata[7:0];
            if (wr_two)
                cfg_two_q <= pwdata[7:0] & rcc_pkg::CFG_TWO_MASK;
            if (wr_mode)
                mode_q <= pwdata[1:0];
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata  <= (psel & ~penable & ~pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ------------------------------------------------------------
    // derived receive controls
    // ------------------------------------------------------------
    // registered so each control comes from a flip-flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            agc_link         <= 1'b0;
            summation_en     <= 1'b0;
            vref_offset_mv   <= 8'h00;
            squelch_step_mv  <= 8'h00;
            start_detect_cnt <= 6'h00;
            coll_eq_slicer   <= 1'b0;
            coll_level_pct   <= 7'h00;
            fast_slicer      <= 1'b0;
            phase_corr_skip  <= 1'b0;
            ref_tc_tenths    <= rcc_pkg::TC_NORM;
            end_level_pct    <= rcc_pkg::PCT_FULL;
            end_detect_en    <= 1'b0;
            stream_424k      <= 1'b0;
            corr_sleep       <= 1'b0;
        end
        else
        begin
            agc_link         <= cfg_one_q[rcc_pkg::B_AGC_LINK];
            summation_en     <= cfg_one_q[rcc_pkg::B_SUM];
            vref_offset_mv   <= sq_hi ? rcc_pkg::VREF_HI_MV : rcc_pkg::VREF_LO_MV;
            squelch_step_mv  <= sq_hi ? rcc_pkg::SQ_HI_MV : rcc_pkg::SQ_LO_MV;
            start_detect_cnt <= start_cnt;
            coll_eq_slicer   <= ~is_bpsk & b6;
            coll_level_pct   <= is_bpsk ? 7'h00 : coll_pct;
            fast_slicer      <= ~is_bpsk & b2;
            phase_corr_skip  <= is_bpsk & b6;
            ref_tc_tenths    <= (is_bpsk & b2) ? rcc_pkg::TC_LONG : rcc_pkg::TC_NORM;
            end_level_pct    <= (is_bpsk & b1) ? rcc_pkg::END_PCT_LO : rcc_pkg::PCT_FULL;
            end_detect_en    <= is_bpsk & b0;
            stream_424k      <= cfg_two_q[rcc_pkg::B_STREAM];
            corr_sleep       <= slp_q == rcc_pkg::SLP_ASLEEP;
        end
    end

endmodule : rcc_top
`default_nettype wire

// ---- rcc_pkg.sv ----
// package: register map, field positions, reset values and timing for the correlator config
package rcc_pkg;
    // register byte addresses (printed offsets not multiples of four: index times four)
    localparam logic [7:0]  IDX_CFG_ONE     = 8'h0c;
    localparam logic [7:0]  IDX_CFG_TWO     = 8'h0d;
    localparam logic [11:0] ADDR_CFG_ONE    = {2'b00, IDX_CFG_ONE, 2'b00};
    localparam logic [11:0] ADDR_CFG_TWO    = {2'b00, IDX_CFG_TWO, 2'b00};
    localparam logic [11:0] ADDR_STATUS     = 12'h0_040;
    localparam logic [11:0] ADDR_MODE       = 12'h0_044;
    // reset values and register two mask
    localparam logic [7:0]  RST_CFG_ONE     = 8'h93;
    localparam logic [7:0]  RST_CFG_TWO     = 8'h00;
    localparam logic [7:0]  CFG_TWO_MASK    = 8'h03;
    localparam logic [1:0]  RST_MODE        = 2'h0;
    // field positions, register one
    localparam int B_AGC_LINK   = 7;
    localparam int B_COLL_PH    = 6;
    localparam int B_SQUELCH    = 5;
    localparam int B_SUM        = 4;
    localparam int B_START_LEN  = 3;
    localparam int B_SLICER_TC  = 2;
    localparam int B_COLL_MSB   = 1;
    localparam int B_COLL_LSB   = 0;
    // field positions, register two
    localparam int B_SLEEP_EXIT = 1;
    localparam int B_STREAM     = 0;
    // reception standards (mode register)
    typedef enum logic [1:0] {
        STD_A106   = 2'b00, // 106k type-A
        STD_BPSK   = 2'b01, // type-A high bit rate, type-B
        STD_F424   = 2'b10, // short sleep exit group
        STD_SLOW   = 2'b11  // vicinity stream, F212: long sleep exit
    } rcc_std_t;
    // start detection lengths
    localparam logic [5:0] START_106_SHORT = 6'd17;
    localparam logic [5:0] START_HI_SHORT  = 6'd9;
    localparam logic [5:0] START_106_LONG  = 6'd33;
    localparam logic [5:0] START_HI_LONG   = 6'd17;
    // collision and end thresholds in percent of data threshold
    localparam logic [6:0] COLL_PCT0 = 7'd16;
    localparam logic [6:0] COLL_PCT1 = 7'd28;
    localparam logic [6:0] COLL_PCT2 = 7'd41;
    localparam logic [6:0] COLL_PCT3 = 7'd53;
    localparam logic [6:0] PCT_FULL  = 7'd100;
    localparam logic [6:0] END_PCT_LO = 7'd66;
    // reference offsets and squelch steps in mV
    localparam logic [7:0] VREF_LO_MV = 8'd50;
    localparam logic [7:0] VREF_HI_MV = 8'd100;
    localparam logic [7:0] SQ_LO_MV   = 8'd100;
    localparam logic [7:0] SQ_HI_MV   = 8'd200;
    // reference time constant in tenths of normal
    localparam logic [4:0] TC_NORM = 5'd10;
    localparam logic [4:0] TC_LONG = 5'd15;
    // sleep timing
    localparam int CLK_MHZ        = 100;
    localparam int SLEEP_IDLE_US  = 18;
    localparam int EXIT_SHORT_US  = 18;
    localparam int EXIT_LONG_US   = 42;
    localparam int SLEEP_IDLE_CYC = SLEEP_IDLE_US * CLK_MHZ;
    localparam int EXIT_SHORT_CYC = EXIT_SHORT_US * CLK_MHZ;
    localparam int EXIT_LONG_CYC  = EXIT_LONG_US * CLK_MHZ;
    localparam int CNT_W          = 16;
    // correlator power states
    typedef enum logic [1:0] {
        SLP_AWAKE  = 2'b00,
        SLP_ASLEEP = 2'b01,
        SLP_WAKING = 2'b10
    } rcc_slp_t;
endpackage : rcc_pkg

// ---- rcc_top_sva.sv ----
// checker: apb timing, register-driven outputs and sleep behaviour
`timescale 1ns/1ps
`default_nettype none
module rcc_chk #(
    parameter int SLEEP_IDLE_CYC = 8
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        corr_pulse,
    input wire logic        rx_on,
    input wire logic        agc_link,
    input wire logic        stream_424k,
    input wire logic        corr_sleep
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic        acc;
    logic        mapped;
    logic        exit_q;
    logic [15:0] idle_q;
    // access-phase decode and shadow of the sleep exit bit
    assign acc    = psel && penable && pwrite;
    assign mapped = paddr inside {rcc_pkg::ADDR_CFG_ONE, rcc_pkg::ADDR_CFG_TWO,
                                  rcc_pkg::ADDR_STATUS, rcc_pkg::ADDR_MODE};
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) exit_q <= 1'b0;
        else if (acc && paddr == rcc_pkg::ADDR_CFG_TWO) exit_q <= pwdata[1];
    // consecutive cycles without a correlator pulse
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) idle_q <= 16'h0000;
        else idle_q <= corr_pulse ? 16'h0000 : idle_q + {15'h0000, idle_q != 16'hffff};
    sequence s_rx_quiet;
        !rx_on [*3];
    endsequence
    a_ready_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr && prdata == 0)
        else $error("unmapped access not refused");
    a_prdata_idle: assert property (!(psel && penable) |-> prdata == 0 && !pready)
        else $error("read data or ready outside access");
    a_agc_write: assert property (acc && paddr == rcc_pkg::ADDR_CFG_ONE
        |=> ##1 agc_link == $past(pwdata[7], 2))
        else $error("agc link does not follow write");
    a_stream_write: assert property (acc && paddr == rcc_pkg::ADDR_CFG_TWO
        |=> ##1 stream_424k == $past(pwdata[0], 2))
        else $error("stream mode does not follow write");
    a_sleep_entry: assert property ($rose(corr_sleep) |-> idle_q >= SLEEP_IDLE_CYC - 1)
        else $error("sleep entered too early");
    a_timer_leave: assert property ($rose(corr_sleep) && !exit_q |=> !corr_sleep)
        else $error("timer exit does not start");
    a_rx_hold: assert property (s_rx_quiet ##0 (corr_sleep && exit_q) |=> corr_sleep)
        else $error("left sleep without receiver on");
    a_rx_wake: assert property (corr_sleep && exit_q && $rose(rx_on) |-> ##[1:3] !corr_sleep)
        else $error("receiver on did not wake");
endmodule : rcc_chk
bind rcc_top rcc_chk #(.SLEEP_IDLE_CYC(SLEEP_IDLE_CYC)) u_chk (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .corr_pulse, .rx_on,
    .agc_link, .stream_424k, .corr_sleep);
`default_nettype wire

// ---- tb.sv ----
// testbench: register access, derived controls and sleep of rcc_top
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, corr_pulse = 1, rx_on = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, r;
    logic pready, pslverr, e, agc_link, summation_en, coll_eq_slicer, fast_slicer;
    logic phase_corr_skip, end_detect_en, stream_424k, corr_sleep;
    logic [7:0] vref_offset_mv, squelch_step_mv;
    logic [5:0] start_detect_cnt;
    logic [6:0] coll_level_pct, end_level_pct;
    logic [4:0] ref_tc_tenths;
    int err_count = 0, checks_done = 0, cyc = 0;
    wire logic [46:0] outs = {agc_link, summation_en, vref_offset_mv, squelch_step_mv,
        start_detect_cnt, coll_eq_slicer, coll_level_pct, fast_slicer, phase_corr_skip,
        ref_tc_tenths, end_level_pct, end_detect_en};
    rcc_top #(.SLEEP_IDLE_CYC(8), .EXIT_SHORT_CYC(6), .EXIT_LONG_CYC(12)) u_rcc_top (.*);
    always #5 pclk = ~pclk;
    // ----------------------------------------
    // bus cycles, comparisons, expectations
    // ----------------------------------------
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1)
            @(posedge pclk);
        r = prdata;
        e = pslverr;
        psel <= 0; penable <= 0;
    endtask : apb
    task automatic chk(input logic [63:0] g, input logic [63:0] x);
        checks_done++;
        if (g !== x)
        begin
            err_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, x);
        end
    endtask : chk
    function automatic logic [46:0] expo(input logic [7:0] v, input logic [1:0] m);
        logic b, h;
        logic [6:0] cp [4];
        cp = '{7'd16, 7'd28, 7'd41, 7'd53};
        b = m == 2'd1;
        h = m != 2'd0;
        return {v[7], v[4], v[5] ? 8'd100 : 8'd50, v[5] ? 8'd200 : 8'd100,
            v[3] ? (h ? 6'd17 : 6'd33) : (h ? 6'd9 : 6'd17), !b & v[6],
            b ? 7'd0 : cp[v[1:0]], !b & v[2], b & v[6], (b & v[2]) ? 5'd15 : 5'd10,
            (b & v[1]) ? 7'd66 : 7'd100, b & v[0]};
    endfunction : expo
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_fields;
        logic [7:0] v;
        chk(outs, expo(8'h93, 2'd0));
        for (int m = 0; m < 4; m++)
            for (int k = 0; k < 8; k++)
            begin
                v = 8'(k * 37);
                apb(1, rcc_pkg::ADDR_MODE, 32'(m));
                apb(1, rcc_pkg::ADDR_CFG_ONE, {24'h0, v});
                repeat (2) @(posedge pclk);
                chk(outs, expo(v, 2'(m)));
                apb(0, rcc_pkg::ADDR_CFG_ONE, 32'h0);
                chk(r, {24'h0, v});
            end
        $display("fields done");
    endtask : t_fields
    task automatic t_regs;
        apb(1, rcc_pkg::ADDR_CFG_TWO, 32'h0000_00ff);
        apb(0, rcc_pkg::ADDR_CFG_TWO, 32'h0);
        chk(r, 32'h0000_0003);
        chk(stream_424k, 1);
        apb(1, 12'h100, 32'h0000_00ff);
        chk(e, 1);
        apb(0, 12'h100, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        apb(1, rcc_pkg::ADDR_CFG_TWO, 32'h0);
        repeat (2) @(posedge pclk);
        chk(stream_424k, 0);
        // advised setting: linked agc with summation, late phase correction
        apb(1, rcc_pkg::ADDR_MODE, 32'h0000_0001);
        apb(1, rcc_pkg::ADDR_CFG_ONE, 32'h0000_00d0);
        repeat (2) @(posedge pclk);
        chk(outs, expo(8'hd0, 2'd1));
        chk({agc_link, summation_en, phase_corr_skip}, 3'b111);
        $display("registers done");
    endtask : t_regs
    task automatic t_sleep(input logic [1:0] m, input logic x);
        int n;
        n = 0;
        apb(1, rcc_pkg::ADDR_MODE, {30'h0, m});
        apb(1, rcc_pkg::ADDR_CFG_TWO, {30'h0, x, 1'b0});
        corr_pulse <= 0;
        while (corr_sleep !== 1'b1 && n < 40)
        begin
            @(posedge pclk);
            n++;
        end
        chk(n >= 7 && n <= 13, 1);
        corr_pulse <= 1;
        if (x)
        begin
            repeat (20) @(posedge pclk);
            chk(corr_sleep, 1);
            rx_on <= 1;
            repeat (4) @(posedge pclk);
            chk(corr_sleep, 0);
            rx_on <= 0;
        end
        else
        begin
            apb(0, rcc_pkg::ADDR_STATUS, 32'h0);
            chk(r, 32'h2);
            repeat (3) @(posedge pclk);
            apb(0, rcc_pkg::ADDR_STATUS, 32'h0);
            chk(r, m == 2'd3 ? 32'h2 : 32'h0);
            repeat (8) @(posedge pclk);
            apb(0, rcc_pkg::ADDR_STATUS, 32'h0);
            chk(r, 32'h0);
        end
        $display("sleep done");
    endtask : t_sleep
    task automatic conclude;
        $display("checks=%0d mismatches=%0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : conclude
    // hang guard
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            err_count++;
            conclude();
        end
    end
    initial
    begin
        repeat (6) @(posedge pclk);
        presetn <= 1;
        apb(0, rcc_pkg::ADDR_CFG_ONE, 32'h0);
        chk(r, 32'h0000_0093);
        t_fields();
        t_regs();
        t_sleep(2'd0, 0);
        t_sleep(2'd3, 0);
        t_sleep(2'd1, 1);
        conclude();
    end
endmodule : tb
`default_nettype wire
